// file: gate_driver_model.sv
// Model of the power-stage gate drivers and the fault line beside them.
// Assumes the phase pin struct of the design and an open-drain fault line.
module gate_driver_model (
	input wire three_phase_pwm_pkg::phase_pins_s phase_pins,
	input wire logic fault,
	output logic forced_cutoff_pin_n,
	output logic [5:0] gate_level,
	output logic shoot_through
);
	timeunit 1ns;
	timeprecision 1ps;
	// Undriven gate inputs sit on pull-downs, so a floating pin reads low
	assign gate_level = phase_pins.out & phase_pins.oe;
	// Fault pulls the line low; otherwise the pull-up holds it high
	assign forced_cutoff_pin_n = fault ? 1'b0 : 1'b1;
	// Both switches of one leg on at once would short the supply
	assign shoot_through = |(gate_level[2:0] & gate_level[5:3]);
endmodule

// file: tb_three_phase_motor_pwm_control.sv
// Self-checking bench for the three-phase PWM control block.
// Assumes the gate driver model in its own file and a 50 MHz clock.
module tb_three_phase_motor_pwm_control;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic f;
		logic [7:0] sp, c0, rc;
		logic [2:0] p, n;
		logic [5:0] eo, ee;
	} row_s;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	three_phase_pwm_pkg::reg_req_s reg_req = '0;
	three_phase_pwm_pkg::phase_pins_s pins;
	logic [7:0] reg_rdata;
	logic fault = 1'b0, running = 1'b0, cut_n, shoot, shoot_seen = 1'b0;
	logic [2:0] ev = 3'h0, pos = 3'h0, neg = 3'h0;
	logic [5:0] port_data = 6'h2d, port_dir = 6'h33, gate;
	wire [4:0] pulse;
	wire [2:0] lv;
	wire reload_lv;
	int cnt[5] = '{0, 0, 0, 0, 0};
	int base[5] = '{0, 0, 0, 0, 0};
	int mismatches = 0, checks_done = 0;
	// Pin cases: fault, special, control 0 written and read, pwm, pins expected
	row_s rows[6] = '{
		'{1'b0, 8'h00, 8'h00, 8'h00, 3'h5, 3'h2, 6'h2d, 6'h33},
		'{1'b0, 8'h00, 8'h04, 8'h04, 3'h5, 3'h2, 6'h00, 6'h00},
		'{1'b0, 8'h00, 8'h0c, 8'h0c, 3'h5, 3'h2, 6'h15, 6'h3f},
		'{1'b1, 8'h00, 8'h0c, 8'h04, 3'h5, 3'h2, 6'h2d, 6'h33},
		'{1'b1, 8'h02, 8'h0c, 8'h04, 3'h5, 3'h2, 6'h00, 6'h00},
		'{1'b0, 8'h00, 8'h0c, 8'h0c, 3'h3, 3'h4, 6'h23, 6'h3f}};

	three_phase_motor_pwm_control i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .forced_cutoff_pin_n(cut_n), .carrier_underflow(ev[0]),
		.carrier_running(running), .phase_v_reload(ev[1]), .one_shot({2'h0, ev[2]}), .shift_out(3'h0),
		.pwm_pos(pos), .pwm_neg(neg), .port_data(port_data), .port_dir(port_dir), .phase_pins(pins),
		.transfer_trigger(pulse[0]), .dead_time_trigger(pulse[1]), .start_trigger(pulse[2]),
		.buffer_load(pulse[3]), .carrier_irq(pulse[4]), .dead_time_enable(lv[2]),
		.secondary_width_enable(lv[1]), .carrier_phase_active(lv[0]), .carrier_reload_timing(reload_lv));
	gate_driver_model i_gate (.phase_pins(pins), .fault(fault), .forced_cutoff_pin_n(cut_n),
		.gate_level(gate), .shoot_through(shoot));

	always #10 ref_clk = ~ref_clk;
	// Pulse tally and sticky shoot-through mark; sampled mid-cycle, away from the launching edge
	always @(negedge ref_clk) begin
		for (int i = 0; i < 5; i++) begin
			if (pulse[i] === 1'b1)
				cnt[i]++;
		end
		if (shoot !== 1'b0)
			shoot_seen <= 1'b1;
	end

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		reg_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		reg_req.rd <= 1'b0;
		#1;
		chk("read data", exp, reg_rdata);
	endtask
	// Pulse one event input n times, then let outputs settle
	task automatic fire(input int k, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			ev[k] <= 1'b1;
			@(posedge ref_clk);
			ev[k] <= 1'b0;
		end
		repeat (4) @(posedge ref_clk);
	endtask
	// Bytes of e: irq, load, start, dead time, transfer
	task automatic counts(input logic [39:0] e);
		for (int i = 0; i < 5; i++)
			chk("pulse count", e[8*i+:8], 8'(cnt[i] - base[i]));
		base = cnt;
	endtask
	task automatic pins_chk(input logic [5:0] eo, input logic [5:0] ee);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("pin enable", {2'h0, ee}, {2'h0, pins.oe});
		chk("pin level", {2'h0, eo & ee}, {2'h0, pins.out & ee});
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		#400000;
		mismatches++;
		close_out();
	end

	initial begin
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(three_phase_pwm_pkg::A_CONTROL_0, 8'h00);
		// Locked write must be ignored
		wr(three_phase_pwm_pkg::A_CONTROL_0, 8'h04);
		rd(three_phase_pwm_pkg::A_CONTROL_0, 8'h00);
		wr(three_phase_pwm_pkg::A_PROTECT, 8'h02);
		foreach (rows[i]) begin
			@(posedge ref_clk);
			fault <= rows[i].f;
			pos <= rows[i].p;
			neg <= rows[i].n;
			repeat (5) @(posedge ref_clk);
			// Cutoff enable only cleared once the pin is back high
			wr(three_phase_pwm_pkg::A_SPECIAL, rows[i].sp);
			wr(three_phase_pwm_pkg::A_CONTROL_0, rows[i].c0);
			pins_chk(rows[i].eo, rows[i].ee);
			rd(three_phase_pwm_pkg::A_CONTROL_0, rows[i].rc);
			$display("pin case %0d done", i);
		end
		// Overlap guard: enable dropped, flag latched, write 1 no effect
		wr(three_phase_pwm_pkg::A_CONTROL_0, 8'h1c);
		@(posedge ref_clk);
		pos <= 3'h1;
		neg <= 3'h1;
		pins_chk(6'h00, 6'h00);
		rd(three_phase_pwm_pkg::A_CONTROL_0, 8'h34);
		@(posedge ref_clk);
		pos <= 3'h0;
		neg <= 3'h0;
		wr(three_phase_pwm_pkg::A_CONTROL_0, 8'h34);
		rd(three_phase_pwm_pkg::A_CONTROL_0, 8'h34);
		wr(three_phase_pwm_pkg::A_CONTROL_0, 8'h14);
		rd(three_phase_pwm_pkg::A_CONTROL_0, 8'h14);
		chk("shoot through", 8'h00, {7'h0, shoot_seen});
		$display("overlap test done");
		// Triggers in triangular mode 0
		base = cnt;
		wr(three_phase_pwm_pkg::A_CONTROL_0, 8'h84);
		rd(three_phase_pwm_pkg::A_CONTROL_0, 8'h04);
		wr(three_phase_pwm_pkg::A_BUFFER, 8'h01);
		fire(0, 2);
		wr(three_phase_pwm_pkg::A_CARRIER, 8'h00);
		@(posedge ref_clk);
		running <= 1'b1;
		wr(three_phase_pwm_pkg::A_CARRIER, 8'h00);
		// Dead-time select stays 0: one-shot falling edge, no complementary guarantee
		wr(three_phase_pwm_pkg::A_CONTROL_1, 8'h01);
		wr(three_phase_pwm_pkg::A_CARRIER, 8'h00);
		fire(2, 1);
		counts(40'h02_01_01_01_04);
		// Sawtooth needs mode 0
		wr(three_phase_pwm_pkg::A_CONTROL_1, 8'h00);
		// Mode first: a trigger in the same write still sees the old mode
		wr(three_phase_pwm_pkg::A_CONTROL_0, 8'h44);
		wr(three_phase_pwm_pkg::A_CONTROL_0, 8'hc4);
		repeat (3) @(posedge ref_clk);
		counts(40'h00_01_00_01_01);
		$display("trigger test done");
		// Level outputs follow function, mode and carrier phase
		wr(three_phase_pwm_pkg::A_CONTROL_0, 8'h04);
		wr(three_phase_pwm_pkg::A_CONTROL_1, 8'h0a);
		repeat (2) @(posedge ref_clk);
		chk("levels", 8'h07, {5'h0, lv});
		// Reload timing switch is allowed only in triangular mode 1
		wr(three_phase_pwm_pkg::A_SPECIAL, 8'h01);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("reload timing", 8'h01, {7'h0, reload_lv});
		wr(three_phase_pwm_pkg::A_SPECIAL, 8'h00);
		// Carrier phase needs mode 1; sawtooth in mode 1 is not allowed
		wr(three_phase_pwm_pkg::A_CONTROL_1, 8'h08);
		repeat (2) @(posedge ref_clk);
		#1;
		chk("levels", 8'h04, {5'h0, lv});
		// Divider: mode 0 every underflow, mode 1 reload edges
		wr(three_phase_pwm_pkg::A_CONTROL_0, 8'h04);
		wr(three_phase_pwm_pkg::A_CONTROL_1, 8'h00);
		wr(three_phase_pwm_pkg::A_DIVIDE, 8'h03);
		base = cnt;
		fire(0, 6);
		counts(40'h02_00_00_00_06);
		wr(three_phase_pwm_pkg::A_CONTROL_1, 8'h02);
		wr(three_phase_pwm_pkg::A_DIVIDE, 8'h03);
		wr(three_phase_pwm_pkg::A_CONTROL_0, 8'h06);
		fire(0, 2);
		fire(1, 5);
		counts(40'h02_00_00_00_02);
		wr(three_phase_pwm_pkg::A_CONTROL_0, 8'h07);
		fire(1, 3);
		counts(40'h01_00_00_00_00);
		$display("divider test done");
		// Cutoff falling edge clears enable, then reset clears all
		wr(three_phase_pwm_pkg::A_CONTROL_0, 8'h0c);
		@(posedge ref_clk);
		fault <= 1'b1;
		repeat (5) @(posedge ref_clk);
		rd(three_phase_pwm_pkg::A_CONTROL_0, 8'h04);
		@(posedge ref_clk);
		fault <= 1'b0;
		sys_rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(three_phase_pwm_pkg::A_CONTROL_0, 8'h00);
		$display("reset test done");
		close_out();
	end
endmodule

// file: three_phase_motor_pwm_control.sv
// Three-phase motor PWM control: registers, forced cutoff, output gating,
// transfer and dead-time triggers, overlap guard and interrupt divider.
// Assumes the carrier timer, one-shot timers, dead-time timers and shift
// register sit outside on the same clock; only the cutoff pin is asynchronous.
//
// Local design decision: strobed register access.

// Function
// [RL1] Function select turns shared pin into cutoff
// [RL2] Cutoff enabled and pin low: pins float
// [RL3] Cutoff disabled and pin low: port drives
// [RL4] Edge select picks reload edge for counter
// [RL5] Mode 1: source picks underflow or edge
// [RL6] Mode 0: counter counts every underflow
// [RL7] First interrupt after n-1, then n
// [RL8] Function select enables dead-time, outputs, counter
// [RL9] Output enable floats or drives PWM pins
// [RL10] Output enable cleared by reset, write, overlap, cutoff
// [RL11] Overlap disable forbids both phases active
// [RL12] Overlap flag sets; only written zero clears
// [RL13] Software trigger fires transfer; reads zero
// [RL14] Buffers load once or every transfer
// [RL15] One-shot falling edge fires dead-time trigger
// [RL16] Transfer from underflow, software or carrier write
// [RL17] Start trigger only when carrier stopped
// [RL18] Mode bit selects secondary width usage
// [RL19] Carrier phase only triangular in mode 1
// [RL20] Software unlocks writes; changes bits while idle
// [RL21] Sawtooth needs mode 0, underflow reload
// [RL22] Shift-edge dead-time trigger only when complementary
// [RL23] Load divider before setting count source
// [RL24] Clear cutoff enable after pin returns high
module three_phase_motor_pwm_control (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire three_phase_pwm_pkg::reg_req_s reg_req,
	output logic [7:0] reg_rdata,
	input wire logic forced_cutoff_pin_n,
	input wire logic carrier_underflow,
	input wire logic carrier_running,
	input wire logic phase_v_reload,
	input wire logic [2:0] one_shot,
	input wire logic [2:0] shift_out,
	input wire logic [2:0] pwm_pos,
	input wire logic [2:0] pwm_neg,
	input wire logic [5:0] port_data,
	input wire logic [5:0] port_dir,
	output three_phase_pwm_pkg::phase_pins_s phase_pins,
	output logic transfer_trigger,
	output logic dead_time_trigger,
	output logic start_trigger,
	output logic buffer_load,
	output logic carrier_irq,
	output logic dead_time_enable,
	output logic secondary_width_enable,
	output logic carrier_phase_active,
	output logic carrier_reload_timing
);

	typedef struct packed {
		logic edge_sel;
		logic cnt_src;
		logic func_sel;
		logic out_en;
		logic ovl_dis;
		logic ovl_det;
		logic saw;
		logic start_opt;
		logic phase_mode;
		logic cphase;
		logic dt_dis;
		logic dt_sel;
		logic reload_timing;
		logic cutoff_en;
		logic prot_wen;
		logic [3:0] div_n;
		logic [3:0] div_cnt;
		logic buf_pending;
		logic sd_meta;
		logic sd_sync;
		logic sd_prev;
		logic reload_prev;
		logic [2:0] shot_prev;
		logic [2:0] shift_prev;
		three_phase_pwm_pkg::phase_pins_s pins;
		logic [7:0] rdata;
		logic transfer;
		logic dt_trig;
		logic start;
		logic buf_load;
		logic irq;
		logic dt_en;
		logic sec_en;
		logic cp_act;
		logic reload_out;
	} state_s;

	state_s q, d;

	function automatic logic rise(input logic prev, input logic cur);
		return cur & ~prev;
	endfunction

	function automatic logic [2:0] fall3(input logic [2:0] prev, input logic [2:0] cur);
		return prev & ~cur;
	endfunction

	// Shared decode terms
	logic wr_c0, wr_c1, wr_sp, wr_div, wr_buf, wr_car, wr_pr, unlocked;
	logic sd_low, sd_fall, overlap, transfer, reload_edge, div_event;
	logic [2:0] ovl_vec, pos_g, neg_g;
	logic [4:0] next_cnt;
	logic [3:0] n_eff;

	always_comb begin
		// Protected registers need the unlock bit first
		unlocked = q.prot_wen; // RL20
		wr_c0 = reg_req.wr && reg_req.addr == three_phase_pwm_pkg::A_CONTROL_0 && unlocked;
		wr_c1 = reg_req.wr && reg_req.addr == three_phase_pwm_pkg::A_CONTROL_1 && unlocked;
		wr_sp = reg_req.wr && reg_req.addr == three_phase_pwm_pkg::A_SPECIAL && unlocked;
		wr_div = reg_req.wr && reg_req.addr == three_phase_pwm_pkg::A_DIVIDE;
		wr_buf = reg_req.wr && reg_req.addr == three_phase_pwm_pkg::A_BUFFER;
		wr_car = reg_req.wr && reg_req.addr == three_phase_pwm_pkg::A_CARRIER;
		wr_pr = reg_req.wr && reg_req.addr == three_phase_pwm_pkg::A_PROTECT;

		// Cutoff pin only counts when the function owns it
		sd_low = q.func_sel & ~q.sd_sync; // RL1
		sd_fall = q.func_sel & q.sd_prev & ~q.sd_sync; // RL1

		ovl_vec = pwm_pos & pwm_neg;
		overlap = q.func_sel & (|ovl_vec);

		// Transfer sources
		transfer = q.func_sel & (carrier_underflow | (wr_c0 & reg_req.wdata[three_phase_pwm_pkg::C0_SWTRIG])
			| (wr_car & q.start_opt)); // RL16 RL13

		// Counter event: edge source only in mode 1 with source bit set
		reload_edge = q.edge_sel ? ~phase_v_reload & q.reload_prev : rise(q.reload_prev, phase_v_reload); // RL4
		if (q.phase_mode && q.cnt_src) begin
			div_event = q.func_sel & reload_edge; // RL5
		end else begin
			div_event = q.func_sel & carrier_underflow; // RL6 RL5
		end
		n_eff = (q.div_n == three_phase_pwm_pkg::DIV_W0) ? three_phase_pwm_pkg::DIV_ONE : q.div_n;
		next_cnt = {1'b0, q.div_cnt} + 5'h01;

		// Forbidden overlap is masked on the pins at once
		pos_g = pwm_pos & ~(ovl_vec & {3{q.ovl_dis}}); // RL11
		neg_g = pwm_neg & ~(ovl_vec & {3{q.ovl_dis}}); // RL11
	end

	// Next-state logic for registers, triggers and pins
	always_comb begin
		d = q;
		d.transfer = 1'b0;
		d.dt_trig = 1'b0;
		d.start = 1'b0;
		d.buf_load = 1'b0;
		d.irq = 1'b0;
		d.rdata = three_phase_pwm_pkg::RD_ZERO;

		// Cutoff synchroniser; first stage feeds only the second
		d.sd_meta = forced_cutoff_pin_n;
		d.sd_sync = q.sd_meta;
		d.sd_prev = q.sd_sync;
		d.reload_prev = phase_v_reload;
		d.shot_prev = one_shot;
		d.shift_prev = shift_out;

		if (wr_pr) begin
			d.prot_wen = reg_req.wdata[three_phase_pwm_pkg::PR_WEN];
		end
		if (wr_c0) begin
			d.edge_sel = reg_req.wdata[three_phase_pwm_pkg::C0_EDGE];
			d.cnt_src = reg_req.wdata[three_phase_pwm_pkg::C0_SRC];
			d.func_sel = reg_req.wdata[three_phase_pwm_pkg::C0_FUNC];
			d.ovl_dis = reg_req.wdata[three_phase_pwm_pkg::C0_OVL_DIS];
			d.saw = reg_req.wdata[three_phase_pwm_pkg::C0_SAW];
			// A one is refused while the cutoff pin is low
			d.out_en = reg_req.wdata[three_phase_pwm_pkg::C0_OE] & ~sd_low; // RL10
			if (!reg_req.wdata[three_phase_pwm_pkg::C0_OVL_DET]) begin
				d.ovl_det = 1'b0; // RL12
			end
			// Source switching on: first interrupt one counter event early
			if (!q.cnt_src && reg_req.wdata[three_phase_pwm_pkg::C0_SRC]) begin
				d.div_cnt = three_phase_pwm_pkg::DIV_ONE; // RL7
			end
		end
		if (wr_c1) begin
			d.start_opt = reg_req.wdata[three_phase_pwm_pkg::C1_START];
			d.phase_mode = reg_req.wdata[three_phase_pwm_pkg::C1_MODE];
			d.cphase = reg_req.wdata[three_phase_pwm_pkg::C1_CPHASE];
			d.dt_dis = reg_req.wdata[three_phase_pwm_pkg::C1_DT_DIS];
			d.dt_sel = reg_req.wdata[three_phase_pwm_pkg::C1_DT_SEL];
		end
		if (wr_sp) begin
			d.reload_timing = reg_req.wdata[three_phase_pwm_pkg::SP_RELOAD];
			d.cutoff_en = reg_req.wdata[three_phase_pwm_pkg::SP_CUTOFF];
		end
		if (wr_div) begin
			d.div_n = reg_req.wdata[3:0];
			d.div_cnt = three_phase_pwm_pkg::DIV_W0;
		end

		// Hardware clears of output enable come after the write
		if (sd_fall || (overlap && q.ovl_dis)) begin
			d.out_en = 1'b0; // RL10
		end
		// Detection wins over a same-cycle software clear
		if (overlap) begin
			d.ovl_det = 1'b1; // RL12
		end

		// Triggers
		d.transfer = transfer; // RL16
		d.start = wr_car & ~carrier_running; // RL17
		if (wr_buf) begin
			d.buf_pending = 1'b1;
		end
		if (transfer) begin
			if (q.saw) begin
				d.buf_load = 1'b1; // RL14
			end else if (q.buf_pending) begin
				d.buf_load = 1'b1; // RL14
				d.buf_pending = wr_buf;
			end
		end
		if (q.func_sel) begin
			if (q.dt_sel) begin
				d.dt_trig = |(shift_out & ~q.shift_prev);
			end else begin
				d.dt_trig = |fall3(q.shot_prev, one_shot); // RL15
			end
			if (q.saw && transfer) begin
				d.dt_trig = 1'b1; // RL15 RL13
			end
		end

		// Interrupt divider; the counter holds while the function is off
		if (div_event) begin
			if (next_cnt >= {1'b0, n_eff}) begin
				d.irq = 1'b1; // RL7
				d.div_cnt = three_phase_pwm_pkg::DIV_W0;
			end else begin
				d.div_cnt = next_cnt[3:0];
			end
		end

		// Mode outputs
		d.dt_en = q.func_sel & ~q.dt_dis; // RL8
		d.sec_en = q.phase_mode; // RL18
		d.cp_act = q.cphase & q.phase_mode & ~q.saw; // RL19
		d.reload_out = q.reload_timing;

		// Pin control: cutoff beats enable; inactive function hands pins to the port
		if (!q.func_sel) begin
			d.pins.out = port_data;
			d.pins.oe = port_dir;
		end else if (sd_low) begin
			if (q.cutoff_en) begin
				d.pins.out = 6'h00; // RL2
				d.pins.oe = 6'h00; // RL2
			end else begin
				d.pins.out = port_data; // RL3
				d.pins.oe = port_dir; // RL3
			end
		end else if (q.out_en) begin
			d.pins.out = {neg_g, pos_g}; // RL9
			d.pins.oe = 6'h3f; // RL9
		end else begin
			d.pins.out = 6'h00; // RL9
			d.pins.oe = 6'h00; // RL9
		end

		// Read data, one cycle after the strobe; unmapped reads zero
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				three_phase_pwm_pkg::A_CONTROL_0: d.rdata = {1'b0, q.saw, q.ovl_det, q.ovl_dis,
					q.out_en, q.func_sel, q.cnt_src, q.edge_sel}; // RL13
				three_phase_pwm_pkg::A_CONTROL_1: d.rdata = {1'b0, q.dt_sel, q.dt_dis, 1'b0, q.cphase,
					1'b0, q.phase_mode, q.start_opt};
				three_phase_pwm_pkg::A_SPECIAL: d.rdata = {q.sd_sync, 5'h00, q.cutoff_en, q.reload_timing};
				three_phase_pwm_pkg::A_DIVIDE: d.rdata = {4'h0, q.div_n};
				three_phase_pwm_pkg::A_PROTECT: d.rdata = {6'h00, q.prot_wen, 1'b0};
				default: d.rdata = three_phase_pwm_pkg::RD_ZERO;
			endcase
		end
	end

	// State register; all control clears on reset, cutoff idles high
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			q <= '0; // RL10
			q.sd_meta <= 1'b1;
			q.sd_sync <= 1'b1;
			q.sd_prev <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign phase_pins = q.pins;
	assign transfer_trigger = q.transfer;
	assign dead_time_trigger = q.dt_trig;
	assign start_trigger = q.start;
	assign buffer_load = q.buf_load;
	assign carrier_irq = q.irq;
	assign dead_time_enable = q.dt_en;
	assign secondary_width_enable = q.sec_en;
	assign carrier_phase_active = q.cp_act;
	assign carrier_reload_timing = q.reload_out;

	a_cutoff_floats: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL2
		q.func_sel && q.cutoff_en && !q.sd_sync |=> phase_pins.oe == 6'h00)
		else $error("cutoff did not float the phase pins");

	a_port_revert: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL3
		q.func_sel && !q.cutoff_en && !q.sd_sync |=> phase_pins.oe == $past(port_dir)
		&& phase_pins.out == $past(port_data))
		else $error("pins did not return to port control");

	a_cutoff_clears_en: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL10
		q.func_sel && q.sd_prev && !q.sd_sync |=> !q.out_en
		##1 (phase_pins.oe == 6'h00 || phase_pins.oe == $past(port_dir)))
		else $error("cutoff edge left output enabled");

	a_overlap_flag: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL12
		q.func_sel && |(pwm_pos & pwm_neg) |=> q.ovl_det)
		else $error("overlap not flagged");

	a_overlap_disable: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL11
		q.func_sel && q.ovl_dis && |(pwm_pos & pwm_neg) |=> !q.out_en)
		else $error("forbidden overlap kept outputs on");

	a_swtrig_reads: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL13
		reg_req.rd && reg_req.addr == three_phase_pwm_pkg::A_CONTROL_0 |=> !reg_rdata[7])
		else $error("software trigger read back as one");

	a_swtrig_fires: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL13
		wr_c0 && q.func_sel && reg_req.wdata[7] |=> transfer_trigger && (dead_time_trigger || !$past(q.saw)))
		else $error("software trigger fired nothing");

	a_start_stopped: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL17
		start_trigger |-> $past(carrier_running) == 1'b0 && $past(wr_car))
		else $error("start trigger while carrier running");

	a_off_no_irq: assert property (@(posedge ref_clk) disable iff (sys_rst) // RL8
		!q.func_sel |=> !carrier_irq && !dead_time_trigger)
		else $error("inactive function produced events");

endmodule

// file: three_phase_pwm_pkg.sv
// Package for the three-phase PWM control block: register map, field positions,
// divider and read-data constants and the structs that carry the register port and phase pins.
// Assumes a single 50 MHz clock domain and a byte-wide register port.
package three_phase_pwm_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] A_CONTROL_0 = 12'h348;
	localparam logic [ADDR_W-1:0] A_CONTROL_1 = 12'h34c;
	localparam logic [ADDR_W-1:0] A_SPECIAL = 12'h350;
	localparam logic [ADDR_W-1:0] A_DIVIDE = 12'h354;
	localparam logic [ADDR_W-1:0] A_BUFFER = 12'h358;
	localparam logic [ADDR_W-1:0] A_CARRIER = 12'h35c;
	localparam logic [ADDR_W-1:0] A_PROTECT = 12'h360;

	// Control 0 fields
	localparam int C0_EDGE = 0;
	localparam int C0_SRC = 1;
	localparam int C0_FUNC = 2;
	localparam int C0_OE = 3;
	localparam int C0_OVL_DIS = 4;
	localparam int C0_OVL_DET = 5;
	localparam int C0_SAW = 6;
	localparam int C0_SWTRIG = 7;

	// Control 1 fields
	localparam int C1_START = 0;
	localparam int C1_MODE = 1;
	localparam int C1_CPHASE = 3;
	localparam int C1_DT_DIS = 5;
	localparam int C1_DT_SEL = 6;

	// Carrier special control fields
	localparam int SP_RELOAD = 0;
	localparam int SP_CUTOFF = 1;

	// Protect register field
	localparam int PR_WEN = 1;

	localparam logic [3:0] DIV_W0 = 4'h0;
	localparam logic [3:0] DIV_ONE = 4'h1;
	localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;

	// Six phase pins: [2:0] positive U,V,W and [5:3] negative U,V,W
	typedef struct packed {
		logic [5:0] out;
		logic [5:0] oe;
	} phase_pins_s;

endpackage
